/* File: hw/scsb_pkg.sv */
`default_nettype none
package scsb_pkg;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_SIGN_EXTEND_WORD = 8'h99;
	localparam logic [7:0] OP_DECIMAL_ADJUST_ADD = 8'h27;
	localparam logic [7:0] OP_STRING_COMPARE_BYTE = 8'hA6;
	localparam logic [7:0] OP_STRING_COMPARE_WORD = 8'hA7;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned INSTR_CLOCKS = 4;
	localparam logic [2:0] INSTR_CNT_LOAD = 3'(INSTR_CLOCKS - 1);

	// ------------------------------------------------------------
	// Arithmetic constants
	// ------------------------------------------------------------
	localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0F;
	localparam logic [7:0] BCD_DIGIT_MAX = 8'h09;
	localparam logic [7:0] LOW_ADJUST = 8'h06;
	localparam logic [7:0] HIGH_LIMIT = 8'h9F;
	localparam logic [7:0] HIGH_ADJUST = 8'h60;
	localparam logic [15:0] SIGN_FILL_NEG = 16'hFFFF;
	localparam logic [15:0] SIGN_FILL_POS = 16'h0000;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] REGS_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PFX_NONE,
		PFX_REPEAT_WHILE_EQUAL,
		PFX_REPEAT_WHILE_UNEQUAL
	} scsb_prefix_t;

	typedef struct packed {
		logic [15:0] accumulator_word;
		logic [15:0] high_data_reg;
		logic [15:0] count_reg;
		logic [15:0] src_index_reg;
		logic [15:0] dest_index_reg;
	} scsb_regs_t;

	typedef struct packed {
		logic overflow_flag;
		logic direction_flag;
		logic interrupt_flag;
		logic trap_flag;
		logic sign_flag;
		logic zero_flag;
		logic auxiliary_carry_flag;
		logic parity_flag;
		logic carry_flag;
	} scsb_flags_t;

	typedef struct packed {
		logic overflow_flag;
		logic sign_flag;
		logic zero_flag;
		logic auxiliary_carry_flag;
		logic parity_flag;
		logic carry_flag;
	} scsb_cmp_flags_t;

endpackage
`default_nettype wire

/* File: hw/scsb_cmp_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module scsb_cmp_unit
	import scsb_pkg::*;
(
	input wire logic [15:0] i_src_data,
	input wire logic [15:0] i_dst_data,
	input wire logic i_word,
	output var scsb_cmp_flags_t o_flags
);

	logic [16:0] diff_w;
	logic [8:0] diff_b;
	logic [4:0] diff_n;

	// ------------------------------------------------------------
	// Source minus destination, difference discarded
	// ------------------------------------------------------------
	assign diff_w = {1'b0, i_src_data} - {1'b0, i_dst_data};
	assign diff_b = {1'b0, i_src_data[7:0]} - {1'b0, i_dst_data[7:0]};
	assign diff_n = {1'b0, i_src_data[3:0]} - {1'b0, i_dst_data[3:0]};

	always_comb begin
		if (i_word) begin
			o_flags.carry_flag = diff_w[16];
			o_flags.sign_flag = diff_w[15];
			o_flags.zero_flag = (diff_w[15:0] == 16'h0000);
			o_flags.overflow_flag = (i_src_data[15] ^ i_dst_data[15])
				& (i_src_data[15] ^ diff_w[15]);
		end else begin
			o_flags.carry_flag = diff_b[8];
			o_flags.sign_flag = diff_b[7];
			o_flags.zero_flag = (diff_b[7:0] == 8'h00);
			o_flags.overflow_flag = (i_src_data[7] ^ i_dst_data[7])
				& (i_src_data[7] ^ diff_b[7]);
		end
		o_flags.auxiliary_carry_flag = diff_n[4];
		o_flags.parity_flag = ~^diff_b[7:0];
	end

endmodule
`default_nettype wire

/* File: hw/scsb_exec_unit.sv */
// Overview of operation
// - Repeat-equal compares in the direction flag's direction, stops on mismatch
// - All pairs matched under repeat-equal: zero set
// - No pair matched under repeat-unequal: zero clear
// - String op steps index registers after each compare, not with a zero repeat count
// - Sign extend decoded from 99, four clocks
// - High data gets accumulator sign fill
// - Sign extend leaves all flags unchanged
// - Decimal adjust decoded from 27, four clocks
// - Low nibble over nine or aux: add six
// - Byte after low adjust over 9F or carry: add 60
// - Indexes step by size, direction picks sign
// - Compare subtracts destination from source, flags only
`timescale 1ns/1ns
`default_nettype none
module scsb_exec_unit
	import scsb_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_start,
	input wire logic [7:0] i_opcode,
	input wire scsb_prefix_t i_prefix,
	input wire scsb_regs_t i_regs,
	input wire scsb_flags_t i_flags,
	input wire logic i_mem_valid,
	input wire logic [15:0] i_src_data,
	input wire logic [15:0] i_dst_data,
	output var scsb_regs_t o_regs,
	output var scsb_flags_t o_flags,
	output logic o_busy,
	output logic o_done,
	output logic o_mem_req,
	output logic o_mem_word,
	output logic [15:0] o_src_addr,
	output logic [15:0] o_dst_addr
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FIXED,
		ST_CMP_ISSUE,
		ST_CMP_WAIT
	} scsb_state_t;

	scsb_state_t state_ff, nxt_state;
	scsb_regs_t regs_ff, nxt_regs;
	scsb_flags_t flags_ff, nxt_flags;
	scsb_prefix_t prefix_ff, nxt_prefix;
	logic [7:0] opcode_ff, nxt_opcode;
	logic [2:0] cnt_ff, nxt_cnt;
	logic done_ff, nxt_done;
	logic req_ff, nxt_req;
	logic word_ff, nxt_word;
	logic busy_ff, nxt_busy;
	scsb_cmp_flags_t cmp_flags;
	logic elem_done;
	logic [15:0] step;
	logic [7:0] adj_low;
	logic [7:0] adj_byte;
	logic stop_rep;

	scsb_cmp_unit u_cmp (
		.i_src_data(i_src_data),
		.i_dst_data(i_dst_data),
		.i_word(word_ff),
		.o_flags(cmp_flags)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	assign elem_done = (state_ff == ST_CMP_WAIT) && req_ff && i_mem_valid;

	always_comb begin
		nxt_state = state_ff;
		nxt_regs = regs_ff;
		nxt_flags = flags_ff;
		nxt_prefix = prefix_ff;
		nxt_opcode = opcode_ff;
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		nxt_req = 1'b0;
		nxt_word = word_ff;
		step = word_ff ? STEP_WORD : STEP_BYTE;
		adj_low = regs_ff.accumulator_word[7:0];
		adj_byte = adj_low;
		stop_rep = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (i_start) begin
					nxt_regs = i_regs;
					nxt_flags = i_flags;
					nxt_prefix = i_prefix;
					nxt_opcode = i_opcode;
					nxt_word = (i_opcode == OP_STRING_COMPARE_WORD);
					if (i_opcode == OP_STRING_COMPARE_BYTE
						|| i_opcode == OP_STRING_COMPARE_WORD) begin
						if (i_prefix != PFX_NONE && i_regs.count_reg == REGS_RESET) begin
							nxt_done = 1'b1;
						end else begin
							nxt_state = ST_CMP_ISSUE;
						end
					end else if (i_opcode == OP_SIGN_EXTEND_WORD
						|| i_opcode == OP_DECIMAL_ADJUST_ADD) begin
						nxt_state = ST_FIXED;
						nxt_cnt = INSTR_CNT_LOAD;
					end else begin
						nxt_done = 1'b1;
					end
				end
			end
			ST_FIXED: begin
				if (cnt_ff != 3'h0) begin
					nxt_cnt = cnt_ff - 3'h1;
				end else begin
					nxt_state = ST_IDLE;
					nxt_done = 1'b1;
					if (opcode_ff == OP_SIGN_EXTEND_WORD) begin
						// Flags deliberately untouched
						nxt_regs.high_data_reg = regs_ff.accumulator_word[15]
							? SIGN_FILL_NEG : SIGN_FILL_POS;
					end else begin
						if ((adj_low & LOW_NIBBLE_MASK) > BCD_DIGIT_MAX
							|| flags_ff.auxiliary_carry_flag) begin
							adj_byte = adj_low + LOW_ADJUST;
							nxt_flags.auxiliary_carry_flag = 1'b1;
						end else begin
							nxt_flags.auxiliary_carry_flag = 1'b0;
						end
						if (adj_byte > HIGH_LIMIT || flags_ff.carry_flag) begin
							adj_byte = adj_byte + HIGH_ADJUST;
							nxt_flags.carry_flag = 1'b1;
						end else begin
							nxt_flags.carry_flag = 1'b0;
						end
						nxt_regs.accumulator_word[7:0] = adj_byte;
					end
				end
			end
			ST_CMP_ISSUE: begin
				nxt_req = 1'b1;
				nxt_state = ST_CMP_WAIT;
			end
			ST_CMP_WAIT: begin
				nxt_req = 1'b1;
				if (elem_done) begin
					nxt_req = 1'b0;
					nxt_flags.overflow_flag = cmp_flags.overflow_flag;
					nxt_flags.sign_flag = cmp_flags.sign_flag;
					nxt_flags.zero_flag = cmp_flags.zero_flag;
					nxt_flags.auxiliary_carry_flag = cmp_flags.auxiliary_carry_flag;
					nxt_flags.parity_flag = cmp_flags.parity_flag;
					nxt_flags.carry_flag = cmp_flags.carry_flag;
					if (flags_ff.direction_flag) begin
						nxt_regs.src_index_reg = regs_ff.src_index_reg - step;
						nxt_regs.dest_index_reg = regs_ff.dest_index_reg - step;
					end else begin
						nxt_regs.src_index_reg = regs_ff.src_index_reg + step;
						nxt_regs.dest_index_reg = regs_ff.dest_index_reg + step;
					end
					if (prefix_ff == PFX_NONE) begin
						stop_rep = 1'b1;
					end else begin
						nxt_regs.count_reg = regs_ff.count_reg - 16'h0001;
						stop_rep = (nxt_regs.count_reg == REGS_RESET)
							|| (prefix_ff == PFX_REPEAT_WHILE_EQUAL
								&& !cmp_flags.zero_flag)
							|| (prefix_ff == PFX_REPEAT_WHILE_UNEQUAL
								&& cmp_flags.zero_flag);
					end
					if (stop_rep) begin
						nxt_state = ST_IDLE;
						nxt_done = 1'b1;
					end else begin
						nxt_state = ST_CMP_ISSUE;
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_busy = (nxt_state != ST_IDLE);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff <= ST_IDLE;
			regs_ff <= '0;
			flags_ff <= '0;
			prefix_ff <= PFX_NONE;
			opcode_ff <= 8'h00;
			cnt_ff <= 3'h0;
			done_ff <= 1'b0;
			req_ff <= 1'b0;
			word_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			regs_ff <= nxt_regs;
			flags_ff <= nxt_flags;
			prefix_ff <= nxt_prefix;
			opcode_ff <= nxt_opcode;
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
			req_ff <= nxt_req;
			word_ff <= nxt_word;
			busy_ff <= nxt_busy;
		end
	end

	assign o_regs = regs_ff;
	assign o_flags = flags_ff;
	assign o_busy = busy_ff;
	assign o_done = done_ff;
	assign o_mem_req = req_ff;
	assign o_mem_word = word_ff;
	assign o_src_addr = regs_ff.src_index_reg;
	assign o_dst_addr = regs_ff.dest_index_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	logic start_idle;
	assign start_idle = i_start && (state_ff == ST_IDLE);

	property p_sign_ext_time;
		start_idle && i_opcode == OP_SIGN_EXTEND_WORD |=> !o_done [*4] ##1 o_done;
	endproperty
	a_sign_ext_time: assert property (p_sign_ext_time) else $error("sign extend not 4 clocks");

	property p_dec_adj_time;
		start_idle && i_opcode == OP_DECIMAL_ADJUST_ADD |-> ##5 o_done && !o_busy;
	endproperty
	a_dec_adj_time: assert property (p_dec_adj_time) else $error("adjust not 4 clocks");

	property p_sign_fill;
		start_idle && i_opcode == OP_SIGN_EXTEND_WORD |-> ##5
			o_regs.high_data_reg == ($past(i_regs.accumulator_word[15], 5)
				? SIGN_FILL_NEG : SIGN_FILL_POS);
	endproperty
	a_sign_fill: assert property (p_sign_fill) else $error("sign fill wrong");

	property p_sign_flags;
		start_idle && i_opcode == OP_SIGN_EXTEND_WORD |-> ##5 o_flags == $past(i_flags, 5);
	endproperty
	a_sign_flags: assert property (p_sign_flags) else $error("sign extend changed flags");

	property p_adj_aux;
		start_idle && i_opcode == OP_DECIMAL_ADJUST_ADD |-> ##5
			o_flags.auxiliary_carry_flag == ($past(i_regs.accumulator_word[3:0], 5) > 4'h9
				|| $past(i_flags.auxiliary_carry_flag, 5));
	endproperty
	a_adj_aux: assert property (p_adj_aux) else $error("aux carry wrong");

	property p_adj_high_kept;
		start_idle && i_opcode == OP_DECIMAL_ADJUST_ADD |-> ##5
			o_regs.accumulator_word[15:8] == $past(i_regs.accumulator_word[15:8], 5);
	endproperty
	a_adj_high_kept: assert property (p_adj_high_kept) else $error("high byte changed");

	property p_index_step;
		elem_done |=> o_src_addr == ($past(flags_ff.direction_flag)
			? $past(o_src_addr) - ($past(o_mem_word) ? STEP_WORD : STEP_BYTE)
			: $past(o_src_addr) + ($past(o_mem_word) ? STEP_WORD : STEP_BYTE));
	endproperty
	a_index_step: assert property (p_index_step) else $error("index step wrong");

	property p_count_dec;
		elem_done && prefix_ff != PFX_NONE |=> o_regs.count_reg == $past(o_regs.count_reg) - 16'h0001;
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("count not decremented");

	property p_repeat_while_equal_prefix_stop;
		elem_done && prefix_ff == PFX_REPEAT_WHILE_EQUAL && !cmp_flags.zero_flag
			|=> o_done && !o_busy && !o_flags.zero_flag;
	endproperty
	a_repeat_while_equal_prefix_stop: assert property (p_repeat_while_equal_prefix_stop) else $error("repeat-equal did not stop");

	property p_cmp_no_store;
		elem_done |=> o_regs.accumulator_word == $past(o_regs.accumulator_word);
	endproperty
	a_cmp_no_store: assert property (p_cmp_no_store) else $error("compare stored result");

	c_sign_ext: cover property (start_idle && i_opcode == OP_SIGN_EXTEND_WORD ##5 o_done);
	c_dec_adj: cover property (start_idle && i_opcode == OP_DECIMAL_ADJUST_ADD ##5 o_done);
	c_repeat_while_equal_prefix_mismatch: cover property (elem_done && prefix_ff == PFX_REPEAT_WHILE_EQUAL
		&& !cmp_flags.zero_flag);
	c_repeat_while_unequal_prefix_full: cover property (elem_done && prefix_ff == PFX_REPEAT_WHILE_UNEQUAL
		&& regs_ff.count_reg == 16'h0001 && !cmp_flags.zero_flag);

endmodule
`default_nettype wire

/* File: tb/scsb_exec_unit_test.sv */
`timescale 1ns/1ns
`default_nettype none
module scsb_exec_unit_test
	import scsb_pkg::*;
;
	typedef struct {
		logic [7:0] op;
		logic [15:0] ax;
		logic af, cf;
		logic [15:0] ax_x, dx_x;
		logic af_x, cf_x;
	} scsb_row_t;
	// ----------------------------------------
	// Cases: input ax, af, cf then expected ax, dx, af, cf
	// ----------------------------------------
	scsb_row_t rows[8] = '{
		'{8'h99, 16'h8000, 1'b1, 1'b1, 16'h8000, 16'hFFFF, 1'b1, 1'b1},
		'{8'h99, 16'h7FFF, 1'b0, 1'b0, 16'h7FFF, 16'h0000, 1'b0, 1'b0},
		'{8'h27, 16'h120F, 1'b0, 1'b0, 16'h1215, 16'h5A5A, 1'b1, 1'b0},
		'{8'h27, 16'hFF9A, 1'b0, 1'b0, 16'hFF00, 16'h5A5A, 1'b1, 1'b1},
		'{8'h27, 16'h0045, 1'b0, 1'b0, 16'h0045, 16'h5A5A, 1'b0, 1'b0},
		'{8'h27, 16'h0000, 1'b1, 1'b1, 16'h0066, 16'h5A5A, 1'b1, 1'b1},
		'{8'h27, 16'h0099, 1'b1, 1'b0, 16'h009F, 16'h5A5A, 1'b1, 1'b0},
		'{8'h27, 16'h00A0, 1'b0, 1'b0, 16'h0000, 16'h5A5A, 1'b0, 1'b1}
	};
	logic i_clk = 1'b0, i_arst_n = 1'b0, i_start = 1'b0, i_mem_valid = 1'b0;
	logic [7:0] i_opcode = 8'h00;
	scsb_prefix_t i_prefix = PFX_NONE;
	scsb_regs_t i_regs = '0;
	scsb_flags_t i_flags = '0;
	logic [15:0] i_src_data = 16'h0000, i_dst_data = 16'h0000;
	scsb_regs_t o_regs;
	scsb_flags_t o_flags;
	logic o_busy, o_done, o_mem_req, o_mem_word;
	logic [15:0] o_src_addr, o_dst_addr;
	logic [15:0] sd[3], dd[3];
	scsb_flags_t f;
	int fails = 0, num_checks = 0, n;

	always #4 i_clk = ~i_clk;

	scsb_exec_unit i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(i_start),
		.i_opcode(i_opcode), .i_prefix(i_prefix), .i_regs(i_regs), .i_flags(i_flags),
		.i_mem_valid(i_mem_valid), .i_src_data(i_src_data), .i_dst_data(i_dst_data),
		.o_regs(o_regs), .o_flags(o_flags), .o_busy(o_busy), .o_done(o_done),
		.o_mem_req(o_mem_req), .o_mem_word(o_mem_word), .o_src_addr(o_src_addr),
		.o_dst_addr(o_dst_addr));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task test_done;
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task tick(inout int c);
		@(negedge i_clk);
		c++;
		if (c > 100) begin
			fails++;
			test_done();
		end
	endtask

	task go(input logic [7:0] op, input scsb_prefix_t p, input scsb_regs_t r,
		input scsb_flags_t fl);
		i_start = 1'b1;
		i_opcode = op;
		i_prefix = p;
		i_regs = r;
		i_flags = fl;
		@(negedge i_clk);
		i_start = 1'b0;
	endtask

	task wait_done(output int c);
		c = 0;
		while (o_done !== 1'b1)
			tick(c);
	endtask

	task dat(input logic [15:0] a, b, c, d, e, g);
		sd = '{a, c, e};
		dd = '{b, d, g};
	endtask

	// Stalls one cycle before answering; address must hold meanwhile
	task elem(input logic [15:0] sa, da, s, d, input logic w, last);
		int c;
		c = 0;
		while (o_mem_req !== 1'b1)
			tick(c);
		check("src_addr", o_src_addr, sa);
		check("dst_addr", o_dst_addr, da);
		check("mem_word", o_mem_word, w);
		@(negedge i_clk);
		check("src_addr_held", o_src_addr, sa);
		i_mem_valid = 1'b1;
		i_src_data = s;
		i_dst_data = d;
		@(negedge i_clk);
		i_mem_valid = 1'b0;
		i_src_data = ~s;
		i_dst_data = ~d;
		check("done", o_done, last);
	endtask

	task run_cmp(input logic [7:0] op, input scsb_prefix_t p, input logic [15:0] cnt,
		input logic df, input int ne);
		logic [15:0] st;
		st = op[0] ? 16'h0002 : 16'h0001;
		if (df)
			st = -st;
		f = '0;
		f.direction_flag = df;
		f.zero_flag = (p != PFX_REPEAT_WHILE_EQUAL);
		go(op, p, '{16'h3333, 16'h4444, cnt, 16'h0100, 16'h0200}, f);
		for (int k = 0; k < ne; k++)
			elem(16'(16'h0100 + st * k), 16'(16'h0200 + st * k), sd[k], dd[k], op[0], k == ne - 1);
		check("src_index", o_regs.src_index_reg, 16'(16'h0100 + st * ne));
		check("dst_index", o_regs.dest_index_reg, 16'(16'h0200 + st * ne));
		check("count", o_regs.count_reg, p == PFX_NONE ? cnt : 16'(cnt - ne));
		check("accum", o_regs.accumulator_word, 16'h3333);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(negedge i_clk);
		check("rst_busy", {o_busy, o_done, o_mem_req}, 3'h0);
		check("rst_regs", o_regs, 80'h0);
		i_arst_n = 1'b1;
		foreach (rows[i]) begin
			f = scsb_flags_t'(9'h155);
			f.auxiliary_carry_flag = rows[i].af;
			f.carry_flag = rows[i].cf;
			go(rows[i].op, PFX_NONE, '{rows[i].ax, 16'h5A5A, 16'h0007, 16'h0100, 16'h0200}, f);
			check("busy", o_busy, 1'b1);
			wait_done(n);
			check("clocks", n, 4);
			check("accum", o_regs.accumulator_word, rows[i].ax_x);
			check("high_data", o_regs.high_data_reg, rows[i].dx_x);
			check("aux", o_flags.auxiliary_carry_flag, rows[i].af_x);
			check("carry", o_flags.carry_flag, rows[i].cf_x);
			if (rows[i].op == 8'h99)
				check("flags", o_flags, f);
		end
		// Start while busy is ignored
		go(8'h99, PFX_NONE, '{16'h8000, 16'h0000, 16'h0001, 16'h0002, 16'h0003}, '0);
		@(negedge i_clk);
		go(8'h27, PFX_NONE, '{16'h000F, 16'h1111, 16'h0001, 16'h0002, 16'h0003}, '0);
		wait_done(n);
		check("busy_clocks", n, 2);
		check("busy_regs", o_regs, {16'h8000, 16'hFFFF, 16'h0001, 16'h0002, 16'h0003});
		// Unknown opcode
		go(8'h00, PFX_NONE, '{16'h1234, 16'h5678, 16'h0009, 16'h0010, 16'h0020}, '0);
		wait_done(n);
		check("unk_clocks", n, 0);
		check("unk_regs", o_regs, {16'h1234, 16'h5678, 16'h0009, 16'h0010, 16'h0020});
		@(negedge i_clk);
		dat(16'hAA41, 16'h5541, 16'h1142, 16'h2242, 16'h0043, 16'hFF43);
		run_cmp(8'hA6, PFX_REPEAT_WHILE_EQUAL, 16'h0003, 1'b0, 3);
		check("zf_all_eq", o_flags.zero_flag, 1'b1);
		dat(16'h1234, 16'h1234, 16'h0001, 16'h0002, 16'h0000, 16'h0000);
		run_cmp(8'hA7, PFX_REPEAT_WHILE_EQUAL, 16'h0005, 1'b1, 2);
		check("zf_diff", o_flags.zero_flag, 1'b0);
		check("cf_diff", o_flags.carry_flag, 1'b1);
		dat(16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0000, 16'h0000);
		run_cmp(8'hA6, PFX_REPEAT_WHILE_UNEQUAL, 16'h0002, 1'b0, 2);
		check("zf_none_eq", o_flags.zero_flag, 1'b0);
		dat(16'h0005, 16'h0006, 16'h0007, 16'h0007, 16'h0000, 16'h0000);
		run_cmp(8'hA6, PFX_REPEAT_WHILE_UNEQUAL, 16'h0004, 1'b1, 2);
		check("zf_match", o_flags.zero_flag, 1'b1);
		dat(16'h0003, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		run_cmp(8'hA7, PFX_NONE, 16'h0007, 1'b1, 1);
		check("cf_single", o_flags.carry_flag, 1'b0);
		// Repeat with zero count
		go(8'hA6, PFX_REPEAT_WHILE_EQUAL, '{16'h0001, 16'h0002, 16'h0000, 16'h0100, 16'h0200}, '0);
		wait_done(n);
		check("cnt0_clocks", n, 0);
		check("cnt0_src", o_regs.src_index_reg, 16'h0100);
		@(negedge i_clk);
		// Reset in mid-run, then recovery
		go(8'h99, PFX_NONE, '{16'hF000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}, '0);
		i_arst_n = 1'b0;
		@(negedge i_clk);
		check("mid_rst", {o_busy, o_done, o_mem_req}, 3'h0);
		check("mid_rst_regs", o_regs, 80'h0);
		i_arst_n = 1'b1;
		go(8'h99, PFX_NONE, '{16'hF000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}, '0);
		wait_done(n);
		check("rec_clocks", n, 4);
		check("rec_dx", o_regs.high_data_reg, 16'hFFFF);
		test_done();
	end
endmodule
`default_nettype wire
